// ===== rtl/tpm_pin_mode.v
// top: APB registers and three pin channels of the timer pin mode control
`include "tpm_consts.vh"
`timescale 1ns/10ps
module tpm_pin_mode #(
  parameter WIDTH = 16
) (
  // clocking
  input wire clk,
  input wire rst,
  input wire clkEn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // timer counters and tick from the rest of the unit
  input wire [WIDTH-1:0] ch4Counter,
  input wire [WIDTH-1:0] ch0Counter,
  input wire ch1CountTick,
  // pins
  input wire ch4PinDIn,
  input wire ch0PinAIn,
  input wire ch0PinCIn,
  output reg ch4PinDOut,
  output reg ch4PinDOe,
  output reg ch0PinAOut,
  output reg ch0PinAOe,
  output reg ch0PinCOut,
  output reg ch0PinCOe
);
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [7:0] ch4PinModeLow;
  reg [7:0] ch0PinModeHigh;
  reg [7:0] ch0PinModeLow;
  reg [1:0] bufferCtrl;
  reg [WIDTH-1:0] cmpD4;
  reg [WIDTH-1:0] cmpA0;
  reg [WIDTH-1:0] cmpC0;
  wire [WIDTH-1:0] capD4;
  wire [WIDTH-1:0] capA0;
  wire [WIDTH-1:0] capC0;
  wire [2:0] pinOut;
  wire [2:0] pinOe;
  wire [2:0] pinSync;
  wire [2:0] pinRaw = {ch0PinCIn, ch0PinAIn, ch4PinDIn};
  // only the rising handshake edge writes; pready is high in the access phase
  wire wrEn = psel & penable & pwrite & pready;
  wire wrD4 = wrEn && (paddr == `TPM_OFF_CH4_MODE_LOW);
  wire wrA0 = wrEn && (paddr == `TPM_OFF_CH0_MODE_HIGH);
  wire wrC0 = wrEn && (paddr == `TPM_OFF_CH0_MODE_LOW);
  function known;
    input [11:0] a;
    begin
      known = (a == `TPM_OFF_CH4_MODE_LOW) || (a == `TPM_OFF_CH0_MODE_HIGH) ||
              (a == `TPM_OFF_CH0_MODE_LOW) || (a == `TPM_OFF_BUFFER_CTRL) ||
              (a == `TPM_OFF_CAP_CH4D) || (a == `TPM_OFF_CAP_CH0A) ||
              (a == `TPM_OFF_CAP_CH0C) || (a == `TPM_OFF_CMP_CH4D) ||
              (a == `TPM_OFF_CMP_CH0A) || (a == `TPM_OFF_CMP_CH0C) ||
              (a == `TPM_OFF_PIN_STATE);
    end
  endfunction
  reg [31:0] next_prdata;
  always @*
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      `TPM_OFF_CH4_MODE_LOW: next_prdata[7:0] = ch4PinModeLow;
      `TPM_OFF_CH0_MODE_HIGH: next_prdata[7:0] = ch0PinModeHigh;
      `TPM_OFF_CH0_MODE_LOW: next_prdata[7:0] = ch0PinModeLow;
      `TPM_OFF_BUFFER_CTRL: next_prdata[1:0] = bufferCtrl;
      `TPM_OFF_CAP_CH4D: next_prdata[WIDTH-1:0] = capD4;
      `TPM_OFF_CAP_CH0A: next_prdata[WIDTH-1:0] = capA0;
      `TPM_OFF_CAP_CH0C: next_prdata[WIDTH-1:0] = capC0;
      `TPM_OFF_CMP_CH4D: next_prdata[WIDTH-1:0] = cmpD4;
      `TPM_OFF_CMP_CH0A: next_prdata[WIDTH-1:0] = cmpA0;
      `TPM_OFF_CMP_CH0C: next_prdata[WIDTH-1:0] = cmpC0;
      `TPM_OFF_PIN_STATE: next_prdata[5:0] = {pinOe, pinOut};
      default: next_prdata = 32'h00000000;
    endcase
  end
  always @(posedge clk)
  begin
    if (rst)
    begin
      ch4PinModeLow <= `TPM_MODE_RESET;
      ch0PinModeHigh <= `TPM_MODE_RESET;
      ch0PinModeLow <= `TPM_MODE_RESET;
      bufferCtrl <= 2'h0;
      cmpD4 <= {WIDTH{1'b0}};
      cmpA0 <= {WIDTH{1'b0}};
      cmpC0 <= {WIDTH{1'b0}};
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      // one wait state: pready rises in the second access cycle
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~known(paddr);
      prdata <= next_prdata;
      if (wrD4)
        ch4PinModeLow <= {pwdata[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB], 4'h0};
      if (wrA0)
        ch0PinModeHigh <= {4'h0, pwdata[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB]};
      if (wrC0)
        ch0PinModeLow <= {4'h0, pwdata[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB]};
      if (wrEn && paddr == `TPM_OFF_BUFFER_CTRL)
        bufferCtrl <= pwdata[1:0];
      if (wrEn && paddr == `TPM_OFF_CMP_CH4D)
        cmpD4 <= pwdata[WIDTH-1:0];
      if (wrEn && paddr == `TPM_OFF_CMP_CH0A)
        cmpA0 <= pwdata[WIDTH-1:0];
      if (wrEn && paddr == `TPM_OFF_CMP_CH0C)
        cmpC0 <= pwdata[WIDTH-1:0];
    end
  end
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : gSync
      tpm_sync2 uSync (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .din(pinRaw[gi]),
        .dout(pinSync[gi])
      );
    end
  endgenerate
  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  // mode fields go in straight from pwdata so the write cycle loads the initial level
  tpm_channel #(.WIDTH(WIDTH), .ALT_SRC(0)) uChD4 (
    .clk(clk), .rst(rst), .clkEn(clkEn),
    .mode(wrD4 ? pwdata[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB] : ch4PinModeLow[`TPM_FLD_HI_MSB:`TPM_FLD_HI_LSB]),
    .modeWrite(wrD4),
    .bufferOn(bufferCtrl[`TPM_BUF_SECOND]),
    .counter(ch4Counter), .compareValue(cmpD4), .altTick(1'b0),
    .pinSync(pinSync[0]), .pinOut(pinOut[0]), .pinOe(pinOe[0]),
    .captured(capD4), .capturePulse()
  );
  tpm_channel #(.WIDTH(WIDTH), .ALT_SRC(1)) uChA0 (
    .clk(clk), .rst(rst), .clkEn(clkEn),
    .mode(wrA0 ? pwdata[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB] : ch0PinModeHigh[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB]),
    .modeWrite(wrA0),
    .bufferOn(1'b0),
    .counter(ch0Counter), .compareValue(cmpA0), .altTick(ch1CountTick),
    .pinSync(pinSync[1]), .pinOut(pinOut[1]), .pinOe(pinOe[1]),
    .captured(capA0), .capturePulse()
  );
  tpm_channel #(.WIDTH(WIDTH), .ALT_SRC(1)) uChC0 (
    .clk(clk), .rst(rst), .clkEn(clkEn),
    .mode(wrC0 ? pwdata[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB] : ch0PinModeLow[`TPM_FLD_LO_MSB:`TPM_FLD_LO_LSB]),
    .modeWrite(wrC0),
    .bufferOn(bufferCtrl[`TPM_BUF_FIRST]),
    .counter(ch0Counter), .compareValue(cmpC0), .altTick(ch1CountTick),
    .pinSync(pinSync[2]), .pinOut(pinOut[2]), .pinOe(pinOe[2]),
    .captured(capC0), .capturePulse()
  );
  always @(posedge clk)
  begin
    if (rst)
    begin
      {ch4PinDOut, ch0PinAOut, ch0PinCOut} <= 3'h0;
      {ch4PinDOe, ch0PinAOe, ch0PinCOe} <= 3'h7;
    end
    else if (clkEn)
    begin
      {ch0PinCOut, ch0PinAOut, ch4PinDOut} <= pinOut;
      {ch0PinCOe, ch0PinAOe, ch4PinDOe} <= pinOe;
    end
  end
endmodule

// ===== include/tpm_consts.vh
// constants and register map for the timer pin mode control block
// Summary of operation
// - top bit clear: compare; 00 keeps pin, 01 drives low; bit2 sets initial level
// - compare mode low bits 10 drive pin high on match; bit2 gives initial level
// - compare mode low bits 11 toggle pin on match from initial level
// - top bit set, low bits 00: capture counter on rising pin edge
// - top bit set, low bits 01: capture counter on falling pin edge
// - top bit set, bit1 set: capture on both edges, bit0 ignored
// - channel 0 only: codes 11xx take channel 1 count clock as capture source
// - with that source, capture whenever channel 1 counter counts up or down
// - after reset each pin outputs low until its mode field is first written
// - buffer bit set: no capture or compare events; a mode write still loads pin enable and initial level
`ifndef TPM_CONSTS_VH
`define TPM_CONSTS_VH
`define TPM_OFF_CH4_MODE_LOW 12'h000
`define TPM_OFF_CH0_MODE_HIGH 12'h004
`define TPM_OFF_CH0_MODE_LOW 12'h008
`define TPM_OFF_BUFFER_CTRL 12'h00C
`define TPM_OFF_CAP_CH4D 12'h010
`define TPM_OFF_CAP_CH0A 12'h014
`define TPM_OFF_CAP_CH0C 12'h018
`define TPM_OFF_CMP_CH4D 12'h01C
`define TPM_OFF_CMP_CH0A 12'h020
`define TPM_OFF_CMP_CH0C 12'h024
`define TPM_OFF_PIN_STATE 12'h028
`define TPM_FLD_HI_MSB 7
`define TPM_FLD_HI_LSB 4
`define TPM_FLD_LO_MSB 3
`define TPM_FLD_LO_LSB 0
`define TPM_MODE_RESET 8'h00
`define TPM_FLD_CAPTURE 3
`define TPM_FLD_LEVEL 2
`define TPM_FLD_SRC 2
`define TPM_FLD_BOTH 1
`define TPM_ACT_KEEP 2'h0
`define TPM_ACT_LOW 2'h1
`define TPM_ACT_HIGH 2'h2
`define TPM_ACT_TOGGLE 2'h3
`define TPM_BUF_FIRST 0
`define TPM_BUF_SECOND 1
`endif

// ===== rtl/tpm_sync2.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tpm_sync2 (
  // clocking
  input wire clk,
  input wire rst,
  input wire clkEn,
  // data
  input wire din,
  output reg dout
);
  reg stage1;
  always @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end
    else if (clkEn)
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// ===== rtl/tpm_channel.v
// one general register channel: compare output and capture
`include "tpm_consts.vh"
`timescale 1ns/10ps
module tpm_channel #(
  parameter WIDTH = 16,
  parameter ALT_SRC = 0
) (
  // clocking
  input wire clk,
  input wire rst,
  input wire clkEn,
  // control
  input wire [3:0] mode,
  input wire modeWrite,
  input wire bufferOn,
  input wire [WIDTH-1:0] counter,
  input wire [WIDTH-1:0] compareValue,
  input wire altTick,
  // pin
  input wire pinSync,
  output reg pinOut,
  output reg pinOe,
  // capture
  output reg [WIDTH-1:0] captured,
  output reg capturePulse
);
  reg pinPrev;
  reg written;
  wire isCapture = mode[`TPM_FLD_CAPTURE];
  wire useAlt = (ALT_SRC != 0) && mode[`TPM_FLD_SRC];
  wire rise = pinSync & ~pinPrev;
  wire fall = ~pinSync & pinPrev;
  wire match = (counter == compareValue);
  reg edgeHit;
  always @*
  begin
    if (useAlt)
      edgeHit = altTick;
    else if (mode[`TPM_FLD_BOTH])
      edgeHit = rise | fall;
    else if (mode[0])
      edgeHit = fall;
    else
      edgeHit = rise;
  end
  always @(posedge clk)
  begin
    if (rst)
    begin
      pinPrev <= 1'b0;
      written <= 1'b0;
      pinOut <= 1'b0;
      pinOe <= 1'b1;
      captured <= {WIDTH{1'b0}};
      capturePulse <= 1'b0;
    end
    else if (clkEn)
    begin
      pinPrev <= pinSync;
      capturePulse <= 1'b0;
      if (modeWrite)
      begin
        written <= 1'b1;
        pinOe <= ~mode[`TPM_FLD_CAPTURE];
        // a write reloads the initial level so a new mode starts clean
        pinOut <= ~mode[`TPM_FLD_CAPTURE] & mode[`TPM_FLD_LEVEL];
      end
      else if (!bufferOn && written)
      begin
        if (isCapture)
        begin
          if (edgeHit)
          begin
            captured <= counter;
            capturePulse <= 1'b1;
          end
        end
        else if (match)
        begin
          case (mode[1:0])
            `TPM_ACT_KEEP: pinOut <= pinOut;
            `TPM_ACT_LOW: pinOut <= 1'b0;
            `TPM_ACT_HIGH: pinOut <= 1'b1;
            `TPM_ACT_TOGGLE: pinOut <= ~pinOut;
            default: pinOut <= pinOut;
          endcase
        end
      end
    end
  end
endmodule

// ===== sim/tpm_pin_model.sv
// far-side pin model: resolves each timer pin from device and external drive
`timescale 1ns/10ps
module tpm_pin_model (
  // device side, bit order c0, a0, d4
  input wire [2:0] devOut,
  input wire [2:0] devOe,
  // external drive from the bench
  input wire [2:0] extLevel,
  // resolved pin levels
  output wire [2:0] pinLevel
);
  // the outside driver backs off wherever the device drives, so no contention
  assign pinLevel = (devOe & devOut) | (~devOe & extLevel);
endmodule

// ===== sim/tpm_pin_mode_chk.sv
// checker: bus and pin timing assertions for the pin mode block
`timescale 1ns/10ps
module tpm_pin_mode_chk (
  // clocking
  input wire clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pins
  input wire ch4PinDOut,
  input wire ch4PinDOe,
  input wire ch0PinAOut,
  input wire ch0PinAOe,
  input wire ch0PinCOut,
  input wire ch0PinCOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rstOut; $fell(rst) |-> {ch0PinCOe, ch0PinAOe, ch4PinDOe, ch0PinCOut, ch0PinAOut, ch4PinDOut} == 6'h38; endproperty
  a_rstOut: assert property (p_rstOut) else $error("pins not driven low after reset");
  property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_inAcc; pready |-> psel && penable; endproperty
  a_inAcc: assert property (p_inAcc) else $error("ready outside access phase");
  property p_err; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h028); endproperty
  a_err: assert property (p_err) else $error("error flag does not match address map");
  property p_rdZero; pready && !pwrite && paddr > 12'h028 |-> prdata == 32'h0; endproperty
  a_rdZero: assert property (p_rdZero) else $error("unmapped read not zero");
  // mode write to a0 lands on the pin two edges after the access edge
  property p_oe; psel && penable && pready && pwrite && paddr == 12'h004 |-> ##2 ch0PinAOe == !$past(pwdata[3], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin enable does not follow mode");
  property p_lvl; psel && penable && pready && pwrite && paddr == 12'h004 && pwdata[3:0] inside {4'h1, 4'h6}
    |-> ##2 ch0PinAOut == $past(pwdata[2], 2); endproperty
  a_lvl: assert property (p_lvl) else $error("initial pin level wrong");
endmodule
bind tpm_pin_mode tpm_pin_mode_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch4PinDOut(ch4PinDOut),
  .ch4PinDOe(ch4PinDOe), .ch0PinAOut(ch0PinAOut), .ch0PinAOe(ch0PinAOe), .ch0PinCOut(ch0PinCOut), .ch0PinCOe(ch0PinCOe));

// ===== sim/tpm_pin_mode_test.sv
// testbench: register access, compare, capture and buffer behaviour of the pin mode block
`timescale 1ns/10ps
module tpm_pin_mode_test;
  logic clk, rst, clkEn, psel, penable, pwrite, ch1CountTick, lastErr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] ch4Counter, ch0Counter;
  logic [2:0] ext;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [2:0] devOut, devOe, pinLevel;
  int badCount, comparisons;
  logic [3:0] capCode [4] = '{4'hA, 4'hB, 4'h8, 4'h9};
  logic [7:0] expRise [4] = '{8'hA1, 8'hB1, 8'h81, 8'h81};
  logic [7:0] expFall [4] = '{8'hA2, 8'hB2, 8'h81, 8'h92};
  tpm_pin_mode #(.WIDTH(16)) u_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch4Counter(ch4Counter), .ch0Counter(ch0Counter), .ch1CountTick(ch1CountTick), .ch4PinDIn(pinLevel[0]),
    .ch0PinAIn(pinLevel[1]), .ch0PinCIn(pinLevel[2]), .ch4PinDOut(devOut[0]), .ch4PinDOe(devOe[0]),
    .ch0PinAOut(devOut[1]), .ch0PinAOe(devOe[1]), .ch0PinCOut(devOut[2]), .ch0PinCOe(devOe[2]));
  tpm_pin_model u_pins (.devOut(devOut), .devOe(devOe), .extLevel(ext), .pinLevel(pinLevel));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one apb transfer; read data and error flag taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20) badCount++;
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counters sit at the match value for exactly one sampling edge
  task automatic hit(input logic [15:0] d, input logic [15:0] a);
    ch4Counter <= d;
    ch0Counter <= a;
    @(posedge clk);
    ch4Counter <= 16'h0000;
    ch0Counter <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask
  // pin edge needs three edges to reach capture; six leaves margin
  task automatic pin(input int k, input logic v, input logic [15:0] n);
    ch0Counter <= n;
    ext[k] <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic printVerdict;
    $display("comparisons=%0d badCount=%0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    badCount++;
    printVerdict;
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ch4Counter = 16'h0000;
    ch0Counter = 16'h0000;
    ch1CountTick = 1'b0;
    ext = 3'h0;
    badCount = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk({26'h0, devOe, devOut}, 32'h38);
    apb(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h38);
    apb(1'b1, 12'h100, 32'h5);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], lastErr}, 32'h1);
    $display("reset and map test done");
    apb(1'b1, 12'h020, 32'h5);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, 12'h004, c);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, c);
      chk({31'h0, devOut[1]}, {31'h0, c[2]});
      hit(16'h0000, 16'h0005);
      e = (c[1:0] == 2'h0) ? c[2] : (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : !c[2];
      chk({31'h0, devOut[1]}, {31'h0, e});
    end
    apb(1'b1, 12'h01C, 32'h7);
    apb(1'b1, 12'h000, 32'h3);
    hit(16'h0007, 16'h0000);
    chk({31'h0, devOut[0]}, 32'h1);
    apb(1'b1, 12'h00C, 32'h2);
    hit(16'h0007, 16'h0000);
    chk({31'h0, devOut[0]}, 32'h1);
    $display("compare test done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 12'h008, {28'h0, capCode[i]});
      pin(2, 1'b1, {8'h00, capCode[i], 4'h1});
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, {24'h0, expRise[i]});
      pin(2, 1'b0, {8'h00, capCode[i], 4'h2});
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, {24'h0, expFall[i]});
    end
    apb(1'b1, 12'h004, 32'hC);
    ch0Counter <= 16'h00C5;
    ch1CountTick <= 1'b1;
    @(posedge clk);
    ch1CountTick <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'hC5);
    pin(1, 1'b1, 16'h00C6);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'hC5);
    // a tick during a frozen cycle must not capture
    clkEn <= 1'b0;
    ch0Counter <= 16'h00D7;
    ch1CountTick <= 1'b1;
    @(posedge clk);
    ch1CountTick <= 1'b0;
    clkEn <= 1'b1;
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'hC5);
    apb(1'b1, 12'h008, 32'hC);
    ch0Counter <= 16'h00E3;
    ch1CountTick <= 1'b1;
    @(posedge clk);
    ch1CountTick <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'hE3);
    apb(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h09);
    chk({26'h0, devOe, devOut}, 32'h09);
    $display("capture test done");
    printVerdict;
  end
endmodule
